// ==== tb/hpcr_host_model.sv ====
/* Host processor model: latches an address, then one read or write.
   Assumes the testbench calls acc and that clk_i is the core clock. */
`timescale 1ns/1ns
`default_nettype none
module hpcr_host_model (
   input wire logic clk_i,
   input wire logic [hpcr_pkg::DATA_W-1:0] data_i,
   input wire logic data_oe_i,
   input wire logic ready_i,
   output var hpcr_pkg::hpcr_pins_t pins_o
);
   import hpcr_pkg::*;
   logic st = 1'b0, cs = 1'b1, al = 1'b0, rs = 1'b1, wr = 1'b1, drv = 1'b0;
   logic [11:0] a = 12'h000;
   logic [7:0] hd = 8'h00;
   // Pad level: device wins while enabled, else the host value
   assign pins_o = '{st, cs, al, rs, wr, a, data_oe_i ? data_i : hd};
   // Undriven pad toggles so a stale value never looks valid
   always @(posedge clk_i) if (!drv) hd <= ~hd;
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #5;
   endtask : step
   // Select the device and latch an address; chip select stays low
   task automatic sel_addr(input logic s, input logic [11:0] ad);
      st = s;
      al = s;
      step(2);
      cs = 1'b0;
      a = ad;
      al = ~s;
      step(6);
      al = s;
      step(6);
   endtask : sel_addr
   // Deselect after the last strobe
   task automatic desel;
      cs = 1'b1;
      step(2);
   endtask : desel
   // One access: latch, one strobe, deselect
   task automatic acc(input logic s, input logic w, input logic [11:0] ad,
      input logic [7:0] wd, output logic [7:0] rv);
      sel_addr(s, ad);
      xfer(s, w, wd, rv);
      desel;
   endtask : acc
   // One strobe at the latched address, a read held until the device answers
   task automatic xfer(input logic s, input logic w, input logic [7:0] wd,
      output logic [7:0] rv);
      int i;
      logic ok;
      if (w) begin
         hd = wd;
         drv = 1'b1;
      end
      wr = ~w;
      rs = w && !s;
      ok = 1'b0;
      // Hold the strobe at least eight cycles, a read until the device answers
      for (i = 0; i < 40 && !(i >= 8 && ok); i++) begin
         step(1);
         ok = w || (data_oe_i && (ready_i != s));
      end
      rv = ok ? pins_o.data : 8'hxx;
      rs = 1'b1;
      wr = 1'b1;
      drv = 1'b0;
      step(8);
   endtask : xfer
endmodule : hpcr_host_model
`default_nettype wire

// ==== tb/hpcr_host_port_chk.sv ====
/* Checker for the host port: strobe, drive and ready relations.
   Assumes it is bound to hpcr_host_port and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module hpcr_host_port_chk (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire hpcr_pkg::hpcr_pins_t pins_i,
   input wire logic [hpcr_pkg::NUM_CNT-1:0] events_i,
   input wire logic [hpcr_pkg::DATA_W-1:0] data_o,
   input wire logic data_oe_o,
   input wire logic ready_or_acknowledge_o,
   input wire logic [hpcr_pkg::DATA_W-1:0] scratch_o
);
   import hpcr_pkg::*;
   logic rdy;
   logic st;
   logic rd_on;
   // Read request as the pins show it in either style
   assign rdy = ready_or_acknowledge_o;
   assign st = pins_i.bus_style_select;
   assign rd_on = !pins_i.cs_n && !pins_i.read_or_data_strobe && (!st || pins_i.write_or_rw_select);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   sequence s_rd_held; rd_on [*8]; endsequence
   sequence s_rd_gone; pins_i.read_or_data_strobe [*8]; endsequence
   rst_idle_a: assert property ($fell(srst_i) |-> !data_oe_o && rdy && scratch_o == 8'h00)
      else $error("outputs not idle after reset");
   oe_cause_a: assert property ($rose(data_oe_o) |-> rd_on)
      else $error("bus driven without a read");
   oe_drive_a: assert property (s_rd_held |-> data_oe_o)
      else $error("read not driven onto bus");
   oe_release_a: assert property (s_rd_gone |-> !data_oe_o)
      else $error("bus not released");
   wr_no_drive_a: assert property (!pins_i.write_or_rw_select [*8] |-> !data_oe_o)
      else $error("bus driven during write");
   data_hold_a: assert property (data_oe_o && $past(data_oe_o) |-> $stable(data_o))
      else $error("read data moved while driven");
   rdy_cause_a: assert property ($fell(rdy) |-> !pins_i.cs_n &&
      (!pins_i.read_or_data_strobe || (!st && !pins_i.write_or_rw_select)))
      else $error("ready moved without a strobe");
   rdy_short_a: assert property (!st && $fell(rdy) |-> ##[1:3] rdy)
      else $error("wait state too long");
   scr_cause_a: assert property (!$stable(scratch_o) |-> !pins_i.cs_n)
      else $error("scratch changed unselected");
   rdy_idle_a: assert property (pins_i.cs_n [*8] |-> rdy)
      else $error("ready not idle");
endmodule : hpcr_host_port_chk
bind hpcr_host_port hpcr_host_port_chk u_chk (.clk_i, .srst_i, .pins_i, .events_i,
   .data_o, .data_oe_o, .ready_or_acknowledge_o, .scratch_o);
`default_nettype wire

// ==== tb/testbench.sv ====
/* Self-checking bench for hpcr_host_port with a host model.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import hpcr_pkg::*;
   logic clk_i = 1'b0, srst_i = 1'b1, data_oe_o, rdy;
   logic [10:0] events_i = 11'h000;
   hpcr_pins_t pins;
   logic [7:0] data_o, scratch_o, v;
   int error_cnt = 0, samples_checked = 0, cyc = 0;
   always #50 clk_i = ~clk_i;
   hpcr_host_port u_hpcr_host_port (.clk_i, .srst_i, .pins_i(pins), .events_i, .data_o,
      .data_oe_o, .ready_or_acknowledge_o(rdy), .scratch_o);
   hpcr_host_model u_host (.clk_i, .data_i(data_o), .data_oe_i(data_oe_o), .ready_i(rdy),
      .pins_o(pins));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      samples_checked++;
      if (s !== e) begin
         error_cnt++;
         $display("Error at %0t ns: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic rd(input logic s, input logic [11:0] ad, input logic [7:0] e);
      logic [7:0] r;
      u_host.acc(s, 1'b0, ad, 8'h00, r);
      chk(r, e);
   endtask : rd
   // Back-to-back one-cycle event pulses on one counter
   task automatic pulse(input int k, input int n);
      repeat (n) begin
         events_i[k] = 1'b1;
         @(posedge clk_i);
         #5;
      end
      events_i = 11'h000;
   endtask : pulse
   task automatic t_reset;
      chk({7'h00, rdy}, 8'h01);
      chk({7'h00, data_oe_o}, 8'h00);
      chk(scratch_o, SCRATCH_RST);
      rd(1'b0, HOLD_OFS, HOLD_RST);
      rd(1'b0, STATUS_OFS, 8'h00);
      rd(1'b1, STATUS_OFS, 8'h01);
   endtask : t_reset
   // Every counter, high byte first, styles alternating
   task automatic t_all;
      for (int k = 0; k < 11; k++) begin
         pulse(k, 257 + k);
         rd(k[0], LCV_HIGH_OFS + 12'(2 * k), 8'h01);
         rd(k[0], HOLD_OFS, 8'(1 + k));
         rd(k[0], LCV_LOW_OFS + 12'(2 * k), 8'h00);
      end
   endtask : t_all
   task automatic t_low;
      pulse(EV_TX_VALID, 515);
      rd(1'b1, LCV_LOW_OFS + 12'h014, 8'h03);
      rd(1'b0, HOLD_OFS, 8'h02);
      rd(1'b1, HOLD_OFS, 8'h02);
      rd(1'b0, LCV_HIGH_OFS + 12'h014, 8'h00);
   endtask : t_low
   task automatic t_write;
      for (int s = 0; s < 2; s++) begin
         u_host.acc(s[0], 1'b1, SCRATCH_OFS, 8'h5a ^ 8'(s), v);
         chk(scratch_o, 8'h5a ^ 8'(s));
         rd(s[0], SCRATCH_OFS, 8'h5a ^ 8'(s));
      end
      u_host.acc(1'b0, 1'b1, HOLD_OFS, 8'hff, v);
      rd(1'b0, HOLD_OFS, 8'h00);
      rd(1'b1, 12'h0ff, UNMAPPED_VAL);
   endtask : t_write
   // Repeated strobes under one latched address, no new latch pulse
   task automatic t_burst;
      logic [7:0] r;
      pulse(EV_LCV, 259);
      rd(1'b0, LCV_LOW_OFS, 8'h03);
      u_host.sel_addr(1'b1, HOLD_OFS);
      repeat (2) begin
         u_host.xfer(1'b1, 1'b0, 8'h00, r);
         chk(r, 8'h01);
      end
      u_host.desel;
      u_host.sel_addr(1'b0, SCRATCH_OFS);
      u_host.xfer(1'b0, 1'b1, 8'ha5, r);
      u_host.xfer(1'b0, 1'b0, 8'h00, r);
      chk(r, 8'ha5);
      u_host.desel;
   endtask : t_burst
   task automatic end_sim;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////
   // Ceiling well above the roughly 5300 cycles the run needs
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         end_sim;
      end
   end
   initial begin
      repeat (6) @(posedge clk_i);
      #5 srst_i = 1'b0;
      repeat (4) @(posedge clk_i);
      #5;
      t_reset;
      t_all;
      t_low;
      t_write;
      t_burst;
      end_sim;
   end
endmodule : testbench
`default_nettype wire

// ==== verilog/hpcr_host_port.sv ====
/*
 * Host port with counter readout: 8-bit bidirectional bus, two strobe
 * styles, clear-on-read counters with a holding byte.
 * Assumes host pins are asynchronous and slow against the 10 MHz clock;
 * the data bus pad is resolved outside from data_o/data_oe_o.
 */
// Behaviour
// - Register data moves over one eight-bit bidirectional data bus.
// - Separate read/write strobes, or data strobe plus read/write select.
// - Single programmed transfers and burst transfers both work.
// - Byte reads and writes work at even and odd addresses.
// - Registers other than counters are one byte wide.
// - Each counter is sixteen bits, split into high and low byte.
// - Reading either counter byte clears the whole counter.
// - Line code violation high byte at 0x50, low byte at 0x51.
// - Holding register sits at address 0x6c.
// - Reading a counter byte copies the other byte into holding.
// - Holding works whether high or low byte is read first.
// - Eleven counters cover line, framing, block, parity, header, cell events.
// - Separate style latches address on falling edge of latch enable.
// - Read strobe low drives data; bus released when it rises.
// - Separate style writes data on rising edge of write strobe.
`timescale 1ns/1ns
`default_nettype none

module hpcr_host_port (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire hpcr_pkg::hpcr_pins_t pins_i,
   input wire logic [hpcr_pkg::NUM_CNT-1:0] events_i,
   output logic [hpcr_pkg::DATA_W-1:0] data_o,
   output logic data_oe_o,
   output logic ready_or_acknowledge_o,
   output logic [hpcr_pkg::DATA_W-1:0] scratch_o
);
   import hpcr_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic style_s, cs_n_s, als_s, rds_s, wrs_s;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] wdat_s;

   hpcr_sync u_sync_style (.clk_i(clk_i), .srst_i(srst_i), .rst_val_i(1'b0),
      .pin_i(pins_i.bus_style_select), .level_o(style_s));
   hpcr_sync u_sync_cs (.clk_i(clk_i), .srst_i(srst_i), .rst_val_i(1'b1),
      .pin_i(pins_i.cs_n), .level_o(cs_n_s));
   hpcr_sync u_sync_als (.clk_i(clk_i), .srst_i(srst_i), .rst_val_i(1'b0),
      .pin_i(pins_i.address_latch_strobe), .level_o(als_s));
   hpcr_sync u_sync_rds (.clk_i(clk_i), .srst_i(srst_i), .rst_val_i(1'b1),
      .pin_i(pins_i.read_or_data_strobe), .level_o(rds_s));
   hpcr_sync u_sync_wrs (.clk_i(clk_i), .srst_i(srst_i), .rst_val_i(1'b1),
      .pin_i(pins_i.write_or_rw_select), .level_o(wrs_s));

   // Address and data are stable around their strobes, so the same
   // three-stage filter per bit is enough; no bus-wide skew matters.
   genvar gi;
   generate
      for (gi = 0; gi < ADDR_W; gi++) begin : g_addr_sync
         hpcr_sync u_a (.clk_i(clk_i), .srst_i(srst_i), .rst_val_i(1'b0),
            .pin_i(pins_i.addr[gi]), .level_o(addr_s[gi]));
      end
      for (gi = 0; gi < DATA_W; gi++) begin : g_data_sync
         hpcr_sync u_d (.clk_i(clk_i), .srst_i(srst_i), .rst_val_i(1'b0),
            .pin_i(pins_i.data[gi]), .level_o(wdat_s[gi]));
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Strobe decode per bus style

   logic als_prev_q, rd_prev_q, wr_prev_q;
   logic rd_act, wr_act, als_fall, wr_rise;
   logic [ADDR_W-1:0] addr_q, addr_d;

   // Style high: data strobe low with select high reads, low writes
   always_comb begin
      if (style_s) begin
         rd_act = !cs_n_s && !rds_s && wrs_s;
         wr_act = !cs_n_s && !rds_s && !wrs_s;
         als_fall = als_prev_q && !als_s; // strobe low is the active level
      end else begin
         rd_act = !cs_n_s && !rds_s;
         wr_act = !cs_n_s && !wrs_s;
         als_fall = als_prev_q && !als_s;
      end
      wr_rise = wr_prev_q && !wr_act;
   end

   // Address is taken on the closing edge of the latch pin, and only
   // while selected, so a latch pulse meant for another device on a
   // shared bus leaves it alone. Enable is active high in one style and
   // the strobe active low in the other, hence opposite edges.
   // Between latch edges the address stays, which is what a burst of
   // strobes relies on; there is no auto-increment, the host steps it.
   always_comb begin
      addr_d = addr_q;
      if (!cs_n_s && !style_s && als_fall) begin
         addr_d = addr_s;
      end else if (!cs_n_s && style_s && !als_prev_q && als_s) begin
         addr_d = addr_s;
      end
   end

   // Pin history for edge detection, and the latched address.
   // History resets to the idle level of the separate-strobe style; a
   // false latch edge after a style change is harmless while unselected.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         als_prev_q <= 1'b0;
         rd_prev_q <= 1'b0;
         wr_prev_q <= 1'b0;
         addr_q <= 12'h000;
      end else begin
         als_prev_q <= als_s;
         rd_prev_q <= rd_act;
         wr_prev_q <= wr_act;
         addr_q <= addr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Counter bank and holding byte

   logic [CNT_W-1:0] count [NUM_CNT];
   logic [NUM_CNT-1:0] clr;
   logic [DATA_W-1:0] hold_q, hold_d;
   logic [DATA_W-1:0] scr_q, scr_d;
   logic [DATA_W-1:0] rdat;
   logic is_cnt;
   logic [3:0] cidx;
   logic [ADDR_W-1:0] off;

   generate
      for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
         hpcr_perf_counter u_cnt (.clk_i(clk_i), .srst_i(srst_i),
            .event_i(events_i[gi]), .clear_i(clr[gi]), .count_o(count[gi]));
      end
   endgenerate

   // Counter pairs: high byte at even offset, low at the following one
   always_comb begin
      off = addr_q - CNT_BASE_OFS;
      is_cnt = (addr_q >= CNT_BASE_OFS) &&
               (off < 12'(2 * NUM_CNT));
      cidx = off[4:1];
   end

   // Read mux: every address byte-wide, odd or even alike
   always_comb begin
      rdat = UNMAPPED_VAL;
      if (is_cnt) begin
         rdat = off[0] ? count[cidx][7:0] : count[cidx][15:8];
      end else if (addr_q == HOLD_OFS) begin
         rdat = hold_q;
      end else if (addr_q == SCRATCH_OFS) begin
         rdat = scr_q;
      end else if (addr_q == STATUS_OFS) begin
         rdat = {7'h00, style_s};
      end
   end

   // Clear and capture happen once at the start of a read; a strobe
   // held low for many cycles must not clear the counter a second time
   logic rd_start;
   assign rd_start = rd_act && !rd_prev_q;

   always_comb begin
      clr = '0;
      hold_d = hold_q;
      if (rd_start && is_cnt) begin
         clr[cidx] = 1'b1;
         // Keep the unread byte, whichever came first
         hold_d = off[0] ? count[cidx][15:8] : count[cidx][7:0];
      end
   end

   // Holding byte; host writes to its address are ignored
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         hold_q <= HOLD_RST;
      end else begin
         hold_q <= hold_d;
      end
   end

   // Writes take effect on the strobe's rising edge, when the data
   // pins have passed the filter with the same latency as the strobe
   always_comb begin
      scr_d = scr_q;
      if (wr_rise && addr_q == SCRATCH_OFS) begin
         scr_d = wdat_s;
      end
   end

   // Scratch register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         scr_q <= SCRATCH_RST;
      end else begin
         scr_q <= scr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Data bus drive and ready

   logic [DATA_W-1:0] dout_q, dout_d;
   logic oe_q, oe_d;
   logic rdy_q, rdy_d;
   logic [1:0] wait_q, wait_d;

   // Data is frozen at read start so the cleared counter never shows
   always_comb begin
      dout_d = dout_q;
      oe_d = rd_act;
      if (rd_start) begin
         dout_d = rdat;
      end
   end

   // Drive registers; the pad resolves outside from data and enable
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         dout_q <= 8'h00;
         oe_q <= 1'b0;
      end else begin
         dout_q <= dout_d;
         oe_q <= oe_d;
      end
   end

   // Ready pin: separate style low means wait, data style low means ack.
   // The wait count reloads whenever the bus is idle, so every access
   // sees the same delay however closely it follows the last one.
   always_comb begin
      wait_d = wait_q;
      if (!rd_act && !wr_act) begin
         wait_d = 2'(READY_CYC);
      end else if (wait_q != 2'h0) begin
         wait_d = wait_q - 2'h1;
      end
      if (style_s) begin
         rdy_d = !((rd_act || wr_act) && wait_q == 2'h0);
      end else begin
         rdy_d = !((rd_act || wr_act) && wait_q != 2'h0);
      end
   end

   // Ready and its wait count; ready idles high in both styles
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdy_q <= 1'b1;
         wait_q <= 2'(READY_CYC);
      end else begin
         rdy_q <= rdy_d;
         wait_q <= wait_d;
      end
   end

   assign data_o = dout_q;
   assign data_oe_o = oe_q;
   assign ready_or_acknowledge_o = rdy_q;
   assign scratch_o = scr_q;

endmodule : hpcr_host_port

`default_nettype wire

// ==== verilog/hpcr_perf_counter.sv ====
/*
 * One sixteen-bit clear-on-read event counter.
 * Assumes events and clears arrive as one-cycle pulses on clk_i.
 */
`timescale 1ns/1ns
`default_nettype none

module hpcr_perf_counter (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic event_i,
   input wire logic clear_i,
   output logic [hpcr_pkg::CNT_W-1:0] count_o
);
   import hpcr_pkg::*;

   logic [CNT_W-1:0] cnt_q, cnt_d;

   // Saturate rather than wrap so a stale read never looks small.
   // An event in the clear cycle starts the new count at one.
   always_comb begin
      cnt_d = cnt_q;
      if (clear_i) begin
         cnt_d = event_i ? 16'h0001 : CNT_RST;
      end else if (event_i && cnt_q != 16'hffff) begin
         cnt_d = cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cnt_q <= CNT_RST;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign count_o = cnt_q;

endmodule : hpcr_perf_counter

`default_nettype wire

// ==== verilog/hpcr_pkg.sv ====
/*
 * Package for the host port with counter readout: register offsets,
 * widths, reset values, timing counts and the carrier structs.
 * Assumes a single 10 MHz core clock for everything that uses it.
 */
package hpcr_pkg;

   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned NUM_CNT = 11;

   // Counter byte pairs start here; high byte even, low byte odd
   localparam logic [11:0] CNT_BASE_OFS = 12'h050;
   localparam logic [11:0] LCV_HIGH_OFS = 12'h050;
   localparam logic [11:0] LCV_LOW_OFS = 12'h051;
   localparam logic [11:0] HOLD_OFS = 12'h06c;
   // Scratch and status registers placed in free space
   localparam logic [11:0] SCRATCH_OFS = 12'h070;
   localparam logic [11:0] STATUS_OFS = 12'h071;

   localparam logic [7:0] SCRATCH_RST = 8'h00;
   localparam logic [7:0] HOLD_RST = 8'h00;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [7:0] UNMAPPED_VAL = 8'h00;

   // Ready delay after a strobe falls, in ns, and in cycles (rounded up)
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned READY_DELAY_NS = 200;
   localparam int unsigned READY_CYC = (READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Counter index of each event
   localparam int unsigned EV_LCV = 0;
   localparam int unsigned EV_FRAMING = 1;
   localparam int unsigned EV_FAR_END_BLOCK_ERROR = 2;
   localparam int unsigned EV_PARITY = 3;
   localparam int unsigned EV_HDR_SINGLE = 4;
   localparam int unsigned EV_HDR_MULTI = 5;
   localparam int unsigned EV_RX_IDLE = 6;
   localparam int unsigned EV_RX_VALID = 7;
   localparam int unsigned EV_RX_DISCARD = 8;
   localparam int unsigned EV_TX_IDLE = 9;
   localparam int unsigned EV_TX_VALID = 10;

   // Host pins as seen by the device
   typedef struct packed {
      logic bus_style_select;
      logic cs_n;
      logic address_latch_strobe;
      logic read_or_data_strobe;
      logic write_or_rw_select;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } hpcr_pins_t;

   // One decoded host access in the core clock domain
   typedef struct packed {
      logic rd;
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } hpcr_access_t;

endpackage : hpcr_pkg

// ==== verilog/hpcr_sync.sv ====
/*
 * Three-stage synchroniser with agreement filter for one pin.
 * Assumes the pin is asynchronous to clk_i; output changes only once
 * stages two and three agree.
 */
`timescale 1ns/1ns
`default_nettype none

module hpcr_sync (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic rst_val_i,
   input wire logic pin_i,
   output logic level_o
);
   import hpcr_pkg::*;

   logic s1_q, s2_q, s3_q, lvl_q;
   logic lvl_d;

   // Filtered level follows only agreed samples
   always_comb begin
      lvl_d = lvl_q;
      if (s2_q == s3_q) begin
         lvl_d = s3_q;
      end
   end

   // Reset loads the pin's idle level, tied per instance, so the first
   // filtered level after reset matches the pin and no false edge follows
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s1_q <= rst_val_i;
         s2_q <= rst_val_i;
         s3_q <= rst_val_i;
         lvl_q <= rst_val_i;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign level_o = lvl_q;

endmodule : hpcr_sync

`default_nettype wire
